// ---- src/sdk_engine.sv ----
// Purpose: command engine for temperature report, bus bridge, live slots, raw lcd, key mask
// Assumes: wishbone classic slave, 32-bit data, one clock; byte engine handles bus timing
// Notes:   ack one cycle after stb; state only changes on accepted commands
// Functional notes
// - temp mask of 32 bits; enabled sensors reported once each second
// - accepted command answered with code or 0x40, zero length mostly
// - bus command takes 2..16 bytes: index 0..32, read count 0..14, payload
// - bridge: reset, address phase, optional write, optional read
// - index 32 skips device selection
// - index 0..31 present sends match then stored rom address
// - length two means no payload; otherwise length-2 payload bytes written
// - zero read count no read; otherwise that many bytes read into answer
// - eight independently enabled live slots showing a fan or temperature reading
// - live command: slot 0..7, type 0 length 2, types 1,2 length 7
// - last parameter is pulses per revolution 1..32 or unit 0/1
// - crc error on temperature slot shows error string
// - slow tachometer shows slow/stop string
// - shown fan forced full for 1/8 s every half second
// - slot setup is kept in boot state
// - raw command: selector data or control, then byte written
// - all keys reported by default; key command sets press and release masks
// - key masks are kept in boot state
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module sdk_engine
  import sdk_pkg::*;
#(
  parameter int BOOST_CYC  = SDK_BOOST_CYC,
  parameter int PERIOD_CYC = SDK_PERIOD_CYC,
  parameter int REPORT_CYC = SDK_REPORT_CYC
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // sensor bus byte engine
  output sdk_bus_t         bus_req_o,
  input  wire logic        bus_done_i,
  input  wire logic [7:0]  bus_rdata_i,
  // live display and sensors
  output sdk_lcd_t         lcd_o,
  output sdk_slot_t [7:0]  slot_o,
  input  wire logic [7:0]  slot_crc_err_i,
  input  wire logic [7:0]  slot_slow_i,
  output logic      [7:0]  slot_alarm_o,
  output logic      [3:0]  fan_force_o,
  // reporting
  output logic      [31:0] temp_report_o,
  output logic      [5:0]  key_press_mask_o,
  output logic      [5:0]  key_release_mask_o
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0]  cmd;
  logic [7:0]  buf_q [16];
  logic [4:0]  len;
  logic        go;
  logic [7:0]  rsp;
  logic [3:0]  rsp_len;
  logic [7:0]  rdat [14];
  logic [31:0] tmask;
  logic [31:0] present;
  logic [63:0] rom [32];
  sdk_slot_t   slots [8];
  sdk_state_t  st;
  logic [3:0]  idx;
  logic        busy;
  logic        wr;
  logic [7:0]  woff;
  function automatic logic lenok(input logic [7:0] c, input logic [4:0] n,
                                 input logic [7:0] b0, input logic [7:0] b1);
    case (c)
      SDK_CMD_TEMP: lenok = (n == 5'h04);
      SDK_CMD_BUS:  lenok = (n >= 5'h02) && (n <= SDK_BUS_MAXLEN)
                            && (b0 <= 8'h20) && (b1 <= SDK_BUS_MAXRD)
                            && ((n != 5'h02) || (b1 != 8'h00));
      SDK_CMD_LIVE: lenok = (b0 <= 8'h07) && (((b1 == 8'h00) && (n == 5'h02))
                            || (((b1 == 8'h01) || (b1 == 8'h02)) && (n == 5'h07)));
      SDK_CMD_RAW:  lenok = (n == 5'h02) && (b0 <= 8'h01);
      SDK_CMD_KEY:  lenok = (n == 5'h02);
      default:      lenok = 1'b0;
    endcase
  endfunction
  // ****************************************
  // wishbone
  // ****************************************
  assign wr = cyc_i && stb_i && we_i && !ack_o && ce_i;
  assign woff = adr_i - SDK_A_ROM0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (ce_i && cyc_i && stb_i && !ack_o) begin
      dat_o <= 32'h0000_0000;
      if (adr_i == SDK_A_STATUS) begin
        dat_o <= {26'h0, rsp_len, 1'b0, busy};
      end else if (adr_i == SDK_A_RSP) begin
        dat_o <= {24'h0, rsp};
      end else if (adr_i >= SDK_A_RDATA && adr_i < SDK_A_RDATA + 8'h04) begin
        dat_o <= {rdat[{adr_i[3:2], 2'b11}], rdat[{adr_i[3:2], 2'b10}],
                  rdat[{adr_i[3:2], 2'b01}], rdat[{adr_i[3:2], 2'b00}]};
      end else if (adr_i == SDK_A_TMASK) begin
        dat_o <= tmask;
      end else if (adr_i == SDK_A_KMASK) begin
        dat_o <= {18'h0, key_release_mask_o, 2'b00, key_press_mask_o};
      end else if (adr_i == SDK_A_PRESENT) begin
        dat_o <= present;
      end
    end
  end
  // command capture: DATA writes append a byte, CMD write starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len <= 5'h00;
      go  <= 1'b0;
      cmd <= 8'h00;
    end else if (ce_i) begin
      go <= 1'b0;
      if (wr && sel_i[0] && adr_i == SDK_A_DATA && len < SDK_BUS_MAXLEN + 5'h01) begin
        buf_q[len[3:0]] <= dat_i[7:0];
        len <= len + 5'h01;
      end else if (wr && sel_i[0] && adr_i == SDK_A_CMD && !busy) begin
        cmd <= dat_i[7:0];
        go  <= 1'b1;
      end else if (st == SDK_DONE) begin
        len <= 5'h00;
      end
    end
  end
  // enumeration results loaded by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      present <= 32'h0000_0000;
    end else if (ce_i && wr && adr_i == SDK_A_PRESENT) begin
      present <= dat_i;
    end else if (ce_i && wr && adr_i >= SDK_A_ROM0) begin
      rom[woff[7:3]][{woff[2], 5'h00} +: 32] <= dat_i;
    end
  end
  // ****************************************
  // sequencer
  // ****************************************
  assign busy = (st != SDK_IDLE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st      <= SDK_IDLE;
      idx     <= 4'h0;
      rsp     <= 8'h00;
      rsp_len <= 4'h0;
    end else if (ce_i) begin
      case (st)
        SDK_IDLE: begin
          if (go) st <= SDK_CHECK;
        end
        SDK_CHECK: begin
          idx <= 4'h0;
          rsp_len <= 4'h0;
          if (!lenok(cmd, len, buf_q[0], buf_q[1])) begin
            rsp <= SDK_RSP_ERR | cmd;
            st  <= SDK_DONE;
          end else if (cmd == SDK_CMD_BUS) begin
            st <= SDK_RESET;
          end else begin
            rsp <= SDK_RSP_OK | cmd;
            st  <= SDK_DONE;
          end
        end
        SDK_RESET: begin
          if (bus_done_i) begin
            idx <= 4'h0;
            if (buf_q[0][5:0] == SDK_BUS_NOADDR) begin
              st <= SDK_WRITE;
            end else begin
              st <= SDK_ADDR;
            end
          end
        end
        SDK_ADDR: begin
          if (bus_done_i) begin
            idx <= idx + 4'h1;
            if (idx == 4'h8 || !present[buf_q[0][4:0]]) begin
              idx <= 4'h0;
              st  <= SDK_WRITE;
            end
          end
        end
        SDK_WRITE: begin
          if (len == 5'h02) begin
            st <= SDK_READ;
          end else if (bus_done_i) begin
            idx <= idx + 4'h1;
            if ({1'b0, idx} == len - 5'h03) begin
              idx <= 4'h0;
              st  <= SDK_READ;
            end
          end
        end
        SDK_READ: begin
          if (buf_q[1] == 8'h00) begin
            rsp <= SDK_RSP_OK | cmd;
            st  <= SDK_DONE;
          end else if (bus_done_i) begin
            rdat[idx] <= bus_rdata_i;
            idx <= idx + 4'h1;
            if ({4'h0, idx} == buf_q[1] - 8'h01) begin
              rsp_len <= buf_q[1][3:0];
              rsp     <= SDK_RSP_OK | cmd;
              st      <= SDK_DONE;
            end
          end
        end
        SDK_DONE: st <= SDK_IDLE;
        default:  st <= SDK_IDLE;
      endcase
    end
  end
  // bus byte requests
  always_comb begin
    bus_req_o = '0;
    case (st)
      SDK_RESET: begin
        bus_req_o.valid = 1'b1;
        bus_req_o.rst   = 1'b1;
      end
      SDK_ADDR: begin
        bus_req_o.valid = 1'b1;
        if (present[buf_q[0][4:0]]) begin
          bus_req_o.data = (idx == 4'h0) ? SDK_BUS_MATCH
                           : rom[buf_q[0][4:0]][{idx[2:0] - 3'h1, 3'h0} +: 8];
        end else begin
          bus_req_o.data = SDK_BUS_SKIP;
        end
      end
      SDK_WRITE: begin
        bus_req_o.valid = (len != 5'h02);
        bus_req_o.data  = buf_q[idx + 4'h2];
      end
      SDK_READ: begin
        bus_req_o.valid = (buf_q[1] != 8'h00);
        bus_req_o.rd    = 1'b1;
      end
      default: bus_req_o = '0;
    endcase
  end
  // ****************************************
  // stored settings applied on accepted commands
  // ****************************************
  logic accept;
  assign accept = (st == SDK_CHECK) && lenok(cmd, len, buf_q[0], buf_q[1]);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmask              <= 32'h0000_0000;
      key_press_mask_o   <= SDK_KEY_ALL;
      key_release_mask_o <= SDK_KEY_ALL;
      lcd_o              <= '0;
    end else if (ce_i) begin
      lcd_o.valid <= 1'b0;
      if (accept && cmd == SDK_CMD_TEMP) begin
        tmask <= {buf_q[3], buf_q[2], buf_q[1], buf_q[0]};
      end
      if (accept && cmd == SDK_CMD_KEY) begin
        key_press_mask_o   <= buf_q[0][5:0];
        key_release_mask_o <= buf_q[1][5:0];
      end
      if (accept && cmd == SDK_CMD_RAW) begin
        lcd_o <= '{valid: 1'b1, kind: buf_q[0][0], data: buf_q[1]};
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        slots[i] <= '0;
      end
    end else if (ce_i && accept && cmd == SDK_CMD_LIVE
                 && (buf_q[1] == 8'h00 || buf_q[1] == 8'h02 || (buf_q[6] >= 8'h01
                 && buf_q[6] <= SDK_PPR_MAX))) begin
      slots[buf_q[0][2:0]] <= '{en: (buf_q[1] != 8'h00), item: buf_q[1][1:0],
                                sensor: buf_q[2][4:0], digits: buf_q[3][2:0],
                                col: buf_q[4][3:0], row: buf_q[5][0],
                                param: buf_q[6][5:0]};
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      slot_o[i] = slots[i];
      slot_alarm_o[i] = slots[i].en && ((slots[i].item == 2'h2 && slot_crc_err_i[i])
                        || (slots[i].item == 2'h1 && slot_slow_i[i]));
    end
  end
  // ****************************************
  // timers: report tick and fan boost
  // ****************************************
  logic [31:0] rcnt;
  logic [31:0] pcnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rcnt <= 32'h0;
      pcnt <= 32'h0;
      temp_report_o <= 32'h0;
    end else if (ce_i) begin
      rcnt <= (rcnt == 32'(REPORT_CYC - 1)) ? 32'h0 : rcnt + 32'h1;
      pcnt <= (pcnt == 32'(PERIOD_CYC - 1)) ? 32'h0 : pcnt + 32'h1;
      temp_report_o <= (rcnt == 32'(REPORT_CYC - 1)) ? tmask : 32'h0;
    end
  end
  always_comb begin
    fan_force_o = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (slots[i].en && slots[i].item == 2'h1 && pcnt < 32'(BOOST_CYC)) begin
        fan_force_o[slots[i].sensor[1:0]] = 1'b1;
      end
    end
  end
  // ****************************************
  // checks
  // ****************************************
  AST_BAD_NO_STATE: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == SDK_CHECK && !lenok(cmd, len, buf_q[0], buf_q[1]) && ce_i)
      |=> ($stable(tmask) && $stable(key_press_mask_o) && rsp[7]))
    else $error("rejected command changed state");
  AST_OK_RSP: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == SDK_CHECK && ce_i && accept && cmd != SDK_CMD_BUS)
      |=> (rsp == (cmd | SDK_RSP_OK) && rsp_len == 4'h0))
    else $error("wrong answer code");
  AST_BUS_RESET_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == SDK_CHECK && ce_i && accept && cmd == SDK_CMD_BUS) |=> st == SDK_RESET)
    else $error("bridge did not start with reset");
  AST_NOADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == SDK_RESET && ce_i && bus_done_i && buf_q[0] == 8'h20) |=> st == SDK_WRITE)
    else $error("index 32 selected a device");
  AST_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == SDK_ADDR && idx == 4'h0 && present[buf_q[0][4:0]])
      |-> bus_req_o.data == SDK_BUS_MATCH)
    else $error("match command missing");
  AST_NOWRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == SDK_WRITE && len == 5'h02 && ce_i) |-> !bus_req_o.valid ##1 st == SDK_READ)
    else $error("payload written for length two");
  AST_KEY: assert property (@(posedge clk_i) disable iff (rst_i)
    (accept && ce_i && cmd == SDK_CMD_KEY) |=> key_release_mask_o == $past(buf_q[1][5:0]))
    else $error("key mask not stored");
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o && ce_i) |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");
endmodule

// ---- src/sdk_pkg.sv ----
// Purpose: constants and carrier types for the sensor/display/key command engine
// Assumes: packets arrive already framed and checked; one byte per beat
// Notes:   codes and field positions shared by engine and bench
package sdk_pkg;
  // ****************************************
  // command codes and answers
  // ****************************************
  localparam logic [7:0] SDK_CMD_TEMP   = 8'h13;
  localparam logic [7:0] SDK_CMD_BUS    = 8'h14;
  localparam logic [7:0] SDK_CMD_LIVE   = 8'h15;
  localparam logic [7:0] SDK_CMD_RAW    = 8'h16;
  localparam logic [7:0] SDK_CMD_KEY    = 8'h17;
  localparam logic [7:0] SDK_RSP_OK     = 8'h40;
  localparam logic [7:0] SDK_RSP_ERR    = 8'hC0;
  localparam logic [7:0] SDK_BUS_MATCH  = 8'h55;
  localparam logic [7:0] SDK_BUS_SKIP   = 8'hCC;
  localparam logic [5:0] SDK_BUS_NOADDR = 6'h20;
  localparam logic [4:0] SDK_BUS_MAXLEN = 5'h10;
  localparam logic [7:0] SDK_BUS_MAXRD  = 8'h0E;
  localparam logic [7:0] SDK_PPR_MAX    = 8'h20;
  localparam logic [5:0] SDK_KEY_ALL    = 6'h3F;
  // ****************************************
  // register map (word offsets are bytes)
  // ****************************************
  localparam logic [7:0] SDK_A_CMD      = 8'h00;
  localparam logic [7:0] SDK_A_DATA     = 8'h04;
  localparam logic [7:0] SDK_A_STATUS   = 8'h08;
  localparam logic [7:0] SDK_A_RSP      = 8'h0C;
  localparam logic [7:0] SDK_A_RDATA    = 8'h10;
  localparam logic [7:0] SDK_A_TMASK    = 8'h14;
  localparam logic [7:0] SDK_A_KMASK    = 8'h18;
  localparam logic [7:0] SDK_A_PRESENT  = 8'h1C;
  localparam logic [7:0] SDK_A_BUSIN    = 8'h20;
  localparam logic [7:0] SDK_A_SLOT0    = 8'h40;
  localparam logic [7:0] SDK_A_ROM0     = 8'h80;
  // ****************************************
  // timing
  // ****************************************
  localparam int          SDK_CLK_HZ     = 125_000_000;
  localparam int          SDK_FANBST_NUM = 1;
  localparam int          SDK_FANBST_DEN = 8;
  localparam int          SDK_FANPER_DEN = 2;
  localparam int          SDK_BOOST_CYC  = SDK_CLK_HZ * SDK_FANBST_NUM / SDK_FANBST_DEN;
  localparam int          SDK_PERIOD_CYC = SDK_CLK_HZ / SDK_FANPER_DEN;
  localparam int          SDK_REPORT_CYC = SDK_CLK_HZ;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       en;
    logic [1:0] item;
    logic [4:0] sensor;
    logic [2:0] digits;
    logic [3:0] col;
    logic       row;
    logic [5:0] param;
  } sdk_slot_t;
  typedef struct packed {
    logic       valid;
    logic       kind;
    logic [7:0] data;
  } sdk_lcd_t;
  typedef struct packed {
    logic       valid;
    logic       rst;
    logic       rd;
    logic [7:0] data;
  } sdk_bus_t;
  typedef enum logic [6:0] {
    SDK_IDLE  = 7'b0000001,
    SDK_CHECK = 7'b0000010,
    SDK_RESET = 7'b0000100,
    SDK_ADDR  = 7'b0001000,
    SDK_WRITE = 7'b0010000,
    SDK_READ  = 7'b0100000,
    SDK_DONE  = 7'b1000000
  } sdk_state_t;
endpackage

// ---- verification/sdk_bus_model.sv ----
// Purpose: behavioural sensor-bus byte engine facing the command engine
// Assumes: one request at a time, held until done
// Notes:   logs every step; answers promptly or slowly
`timescale 1ns/1ps
module sdk_bus_model
  import sdk_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // pacing
  input  wire logic       slow_i,
  // byte requests
  input  sdk_bus_t        req_i,
  output logic            done_o,
  output logic      [7:0] rdata_o
);
  // ****************************************
  // byte engine
  // ****************************************
  logic [9:0] log_q[$];
  logic [3:0] wait_cnt;
  logic [7:0] rd_ctr;
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_o   <= 1'b0;
      wait_cnt <= 4'h0;
      rd_ctr   <= 8'hA0;
      rdata_o  <= 8'h5A;
    end else if (done_o) begin
      done_o  <= 1'b0;
      rdata_o <= ~rdata_o;
    end else if (req_i.valid === 1'b1) begin
      if (wait_cnt >= (slow_i ? 4'h5 : 4'h0)) begin
        done_o   <= 1'b1;
        wait_cnt <= 4'h0;
        log_q.push_back({req_i.rst, req_i.rd,
                         req_i.rst ? 8'h00 : (req_i.rd ? rd_ctr : req_i.data)});
        if (req_i.rst) rd_ctr <= 8'hA0;
        else if (req_i.rd) rd_ctr <= rd_ctr + 8'h01;
        rdata_o  <= req_i.rd ? rd_ctr : ~rd_ctr;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// ---- verification/sdk_engine_tb.sv ----
// Purpose: self-checking bench for the command engine
// Assumes: short timing parameters 4, 16, 32
// Notes:   one task per scenario
`timescale 1ns/1ps
module sdk_engine_tb;
  import sdk_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0, ce = 1'b1;
  logic      [7:0]  adr = 8'h00;
  logic      [31:0] wdat = 32'h0, dat_o;
  logic             ack_o, bus_done;
  logic      [7:0]  bus_rdata, crc_err = 8'h00, slow_in = 8'h00, slot_alarm;
  sdk_bus_t         bus_req;
  sdk_lcd_t         lcd, lcd_seen;
  sdk_slot_t [7:0]  slot;
  logic      [3:0]  fan_force;
  logic      [31:0] temp_report;
  logic      [5:0]  kpress, krel;
  int               errors = 0, n_tests = 0;
  initial forever #4 clk_i = ~clk_i;
  sdk_engine #(.BOOST_CYC(4), .PERIOD_CYC(16), .REPORT_CYC(32)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .bus_req_o(bus_req), .bus_done_i(bus_done), .bus_rdata_i(bus_rdata), .lcd_o(lcd),
    .slot_o(slot), .slot_crc_err_i(crc_err), .slot_slow_i(slow_in),
    .slot_alarm_o(slot_alarm), .fan_force_o(fan_force), .temp_report_o(temp_report),
    .key_press_mask_o(kpress), .key_release_mask_o(krel));
  sdk_bus_model bm (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .req_i(bus_req),
    .done_o(bus_done), .rdata_o(bus_rdata));
  always @(posedge clk_i) if (lcd.valid === 1'b1) lcd_seen <= lcd;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) check(32'h0, 32'h1, "no bus answer");
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] b[$], input logic [7:0] rsp);
    logic [31:0] q;
    int n;
    foreach (b[i]) wb(1'b1, SDK_A_DATA, {24'h0, b[i]}, q);
    wb(1'b1, SDK_A_CMD, {24'h0, c}, q);
    n = 0;
    do begin wb(1'b0, SDK_A_STATUS, 32'h0, q); n++; end while (q[0] !== 1'b0 && n < 200);
    wb(1'b0, SDK_A_RSP, 32'h0, q);
    check(32'(q[7:0]), 32'(rsp), "answer code");
  endtask
  task automatic chk_log(input logic [9:0] e[$]);
    check(32'(bm.log_q.size()), 32'(e.size()), "bus step count");
    foreach (e[i]) if (i < bm.log_q.size()) check(32'(bm.log_q[i]), 32'(e[i]), "bus step");
    bm.log_q.delete();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_keys();
    logic [31:0] q;
    check(32'({krel, kpress}), 32'hFFF, "key masks after reset");
    for (int i = 0; i < 6; i++) begin
      cmd(SDK_CMD_KEY, '{8'(1 << i), 8'(~(1 << i) & 8'h3F)}, 8'h57);
      check(32'({krel, kpress}), 32'({6'(~(1 << i)), 6'(1 << i)}), "key masks");
    end
    wb(1'b0, SDK_A_KMASK, 32'h0, q);
    check(q & 32'h3F3F, 32'h1F20, "key mask readback");
  endtask
  task automatic t_temp();
    logic [31:0] q;
    int n, p;
    // only thermometer-family sensors 0, 15 and 31 are enabled
    cmd(SDK_CMD_TEMP, '{8'h01, 8'h80, 8'h00, 8'h80}, 8'h53);
    wb(1'b0, SDK_A_TMASK, 32'h0, q);
    check(q, 32'h80008001, "temperature mask");
    n = 0;
    while (temp_report !== 32'h80008001 && n < 80) begin @(posedge clk_i); n++; end
    p = 0;
    repeat (64) begin @(posedge clk_i); if (temp_report === 32'h80008001) p++; end
    check(32'(p), 32'h2, "reports per interval");
    ce <= 1'b0;
    p = 0;
    repeat (64) begin @(posedge clk_i); if (temp_report === 32'h80008001) p++; end
    ce <= 1'b1;
    check(32'(p), 32'h0, "no report while frozen");
    p = 0;
    repeat (40) begin @(posedge clk_i); if (temp_report === 32'h80008001) p++; end
    check(32'(p), 32'h1, "report after freeze");
  endtask
  task automatic t_raw();
    for (int s = 0; s < 2; s++) begin
      cmd(SDK_CMD_RAW, '{8'(s), 8'hA5 ^ 8'(s)}, 8'h56);
      check(32'(lcd_seen), 32'({1'b1, 1'(s), 8'hA5 ^ 8'(s)}), "raw controller write");
    end
  endtask
  task automatic t_bridge();
    logic [31:0] q;
    bm.log_q.delete();
    cmd(SDK_CMD_BUS, '{8'h20, 8'h02, 8'h11}, 8'h54);
    chk_log('{10'h200, 10'h011, 10'h1A0, 10'h1A1});
    wb(1'b0, SDK_A_STATUS, 32'h0, q);
    check(32'(q[5:0]), 32'h08, "answer length");
    wb(1'b0, SDK_A_RDATA, 32'h0, q);
    check(32'(q[15:0]), 32'hA1A0, "read bytes");
    slow <= 1'b1;
    wb(1'b1, SDK_A_PRESENT, 32'h8, q);
    wb(1'b1, 8'h98, 32'h44332211, q);
    wb(1'b1, 8'h9C, 32'h88776655, q);
    cmd(SDK_CMD_BUS, '{8'h03, 8'h00, 8'hE1, 8'hE2}, 8'h54);
    chk_log('{10'h200, 10'h055, 10'h011, 10'h022, 10'h033, 10'h044, 10'h055, 10'h066,
              10'h077, 10'h088, 10'h0E1, 10'h0E2});
    slow <= 1'b0;
    cmd(SDK_CMD_BUS, '{8'h20, 8'h01}, 8'h54);
    chk_log('{10'h200, 10'h1A0});
    cmd(SDK_CMD_BUS, '{8'h04, 8'h01}, 8'h54);
    chk_log('{10'h200, 10'h0CC, 10'h1A0});
  endtask
  task automatic t_bad();
    logic [31:0] q;
    logic [9:0]  none[$];
    cmd(SDK_CMD_KEY, '{8'h01, 8'h02, 8'h03}, 8'hD7);
    check(32'({krel, kpress}), 32'h7E0, "masks kept");
    cmd(SDK_CMD_TEMP, '{8'h01, 8'h02, 8'h03}, 8'hD3);
    wb(1'b0, SDK_A_TMASK, 32'h0, q);
    check(q, 32'h80008001, "mask kept");
    cmd(SDK_CMD_LIVE, '{8'h08, 8'h00}, 8'hD5);
    cmd(SDK_CMD_RAW, '{8'h02, 8'h00}, 8'hD6);
    cmd(SDK_CMD_BUS, '{8'h20, 8'h0F}, 8'hD4);
    cmd(SDK_CMD_BUS, '{8'h21, 8'h01}, 8'hD4);
    cmd(SDK_CMD_BUS, '{8'h20, 8'h00}, 8'hD4);
    chk_log(none);
  endtask
  task automatic t_live();
    int n, h;
    // host keeps fields in range and slots apart
    cmd(SDK_CMD_LIVE, '{8'h02, 8'h01, 8'h01, 8'h04, 8'h0C, 8'h01, 8'h02}, 8'h55);
    check(32'(slot[2]), 32'({1'h1, 2'h1, 5'h01, 3'h4, 4'hC, 1'h1, 6'h02}), "fan slot");
    cmd(SDK_CMD_LIVE, '{8'h05, 8'h02, 8'h07, 8'h05, 8'h0B, 8'h00, 8'h01}, 8'h55);
    check(32'(slot[5]), 32'({1'h1, 2'h2, 5'h07, 3'h5, 4'hB, 1'h0, 6'h01}), "temp slot");
    slow_in <= 8'h20;
    crc_err <= 8'h04;
    repeat (2) @(posedge clk_i);
    check(32'(slot_alarm), 32'h00, "alarm on wrong item");
    slow_in <= 8'h04; crc_err <= 8'h20;
    repeat (2) @(posedge clk_i);
    check(32'(slot_alarm & 8'h24), 32'h24, "alarm strings");
    n = 0;
    while (fan_force[1] !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
    h = 0;
    repeat (16) begin @(posedge clk_i); if (fan_force[1] === 1'b1) h++; end
    check(32'(h >= 1 && h <= 4), 32'h1, "fan boost share");
    cmd(SDK_CMD_LIVE, '{8'h02, 8'h00}, 8'h55);
    check(32'(slot[2].en), 32'h0, "slot off");
    check(32'(slot[5].en), 32'h1, "other slot kept");
    repeat (20) @(posedge clk_i);
    check(32'(fan_force[1]), 32'h0, "boost ends");
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_keys();
    t_temp();
    t_raw();
    t_bridge();
    t_bad();
    t_live();
    close_out();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    errors++;
    close_out();
  end
endmodule
